// >>> logic/strap_capture_pkg.sv
/*
 Package for the power-on strap capture block: register offsets, strap pin
 positions, field positions and clock divisor codes.
 Assumes the strap pins are the shared memory data bus, sampled synchronously.
*/
`default_nettype none
package strap_capture_pkg;
	// Register offsets, byte-wide register port
	localparam logic [7:0] STRAP_REG0_OFFSET = 8'h4a;
	localparam logic [7:0] STRAP_REG2_OFFSET = 8'h4c;
	localparam logic [7:0] HCLK_STRAP_OFFSET = 8'h5f;

	// Strap pin positions on the memory data bus
	localparam int PIN_HCLK_SPD_LO = 2;  // Pins 3..2
	localparam int PIN_PCI_DIV_A   = 4;
	localparam int PIN_SYNC        = 5;
	localparam int PIN_PLL_LO      = 6;  // Pins 7..6
	localparam int PIN_PCI_DIV_B   = 17;
	localparam int PIN_DOT_DIR     = 20;
	localparam int PIN_HCLK_SPD_HI = 24; // Pins 26..24
	localparam int PIN_BUS_SEL     = 44;

	// Field positions in strap register 0, strap register 2 and the host clock strap register
	localparam int F0_PLL_LO   = 6;
	localparam int F0_BUS_SEL  = 5;
	localparam int F0_PCI_DIVA = 4;
	localparam int F0_SYNC     = 2;
	localparam int F2_DOT_DIR  = 4;
	localparam int FH_SPEED_LO = 3;

	// Reset value of unread registers and reserved bits
	localparam logic [7:0] REG_RESET = 8'h00;

	// Divisor codes for the PCI clock
	localparam logic [2:0] DIV_BY_2 = 3'h2;
	localparam logic [2:0] DIV_BY_3 = 3'h3;
	localparam logic [2:0] DIV_BY_4 = 3'h4;

	typedef enum logic [1:0] {
		ST_RESET   = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_HOLD    = 2'b10
	} capture_state_t;

	// Captured strap set, shared by the capture and the clock logic
	typedef struct packed {
		logic [1:0] pll_range;
		logic       bus_local;
		logic       pci_div_a;
		logic       pci_div_b;
		logic       mem_sync;
		logic       dot_out;
		logic [4:0] hclk_speed;
	} strap_set_t;
endpackage
`default_nettype wire

// >>> logic/power_on_strap_capture.sv
/*
 Power-on strap capture: samples the memory data pins as the reset ends, holds
 them in read-only strap registers and derives the clock and bus set-up.
 Assumes board resistors hold the straps steady while srst is high and that
 the pins are synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01: Strap register 0 takes the levels on strap pins 7..4 as reset ends.
// RULE_02: PCI clock is host clock /4 if strap A low, /3 if A high B low, /2 if both high.
// RULE_03: Register 0 bit 4 shows divisor strap A and bits 1..0 show divisor strap B.
// RULE_04: Register 0 bit 2 shows the memory/host sync strap, 1 meaning synchronised.
// RULE_05: The bus-select strap picks ISA at 0 or local bus at 1, shown in bit 5.
// RULE_06: Register 0 bits 7..6 show the two PLL range straps that set up the PCI PLL.
// RULE_07: The board holds marked straps at their pull level through reset.
// RULE_08: The dot clock strap makes the dot clock pin an input at 0, an output at 1.
// RULE_09: Five host clock speed straps program the synthesizer and are readable.
// RULE_10: Straps are sampled once at reset release and held until the next reset.
module power_on_strap_capture
	import strap_capture_pkg::*;
#(
	parameter int PIN_COUNT = 64
) (
	input  wire logic                 clock,
	input  wire logic                 srst,
	input  wire logic [PIN_COUNT-1:0] strap_sample_pins,
	input  wire logic [7:0]           reg_addr,
	output var  logic [7:0]           reg_rdata,
	output var  logic                 pci_clock_out,
	output var  logic                 mem_host_sync,
	output var  logic                 local_bus_mode,
	output var  logic [1:0]           pci_pll_range,
	output var  logic                 dot_clock_oe_n,
	output var  logic [4:0]           hclk_speed_code,
	output var  logic                 straps_valid
);
	import strap_capture_pkg::*;

	capture_state_t state;
	capture_state_t next_state;
	strap_set_t     straps;
	strap_set_t     next_straps;
	logic [2:0]     div_count;
	logic [2:0]     div_ratio;
	logic [2:0]     next_div_count;
	logic [7:0]     reg0_value;
	logic [7:0]     reg2_value;
	logic [7:0]     hclk_value;
	logic [7:0]     next_rdata;
	logic           capture_now;

	// Capture only in the first cycle after release; later pin activity is memory traffic
	assign capture_now = (state == ST_CAPTURE); // [RULE_10]

	// Sample the strap pins into the captured set
	assign next_straps.pll_range  = strap_sample_pins[PIN_PLL_LO +: 2]; // [RULE_01] [RULE_06]
	assign next_straps.bus_local  = strap_sample_pins[PIN_BUS_SEL];     // [RULE_05]
	assign next_straps.pci_div_a  = strap_sample_pins[PIN_PCI_DIV_A];   // [RULE_01]
	assign next_straps.pci_div_b  = strap_sample_pins[PIN_PCI_DIV_B];
	assign next_straps.mem_sync   = strap_sample_pins[PIN_SYNC];        // [RULE_04]
	assign next_straps.dot_out    = strap_sample_pins[PIN_DOT_DIR];     // [RULE_08]
	assign next_straps.hclk_speed = {strap_sample_pins[PIN_HCLK_SPD_LO +: 2],
		strap_sample_pins[PIN_HCLK_SPD_HI +: 3]};                       // [RULE_09]

	// Sequencer: reset, one capture cycle, then hold until the next reset
	always_comb begin
		case (state)
			ST_RESET:   next_state = ST_CAPTURE;
			ST_CAPTURE: next_state = ST_HOLD;
			default:    next_state = ST_HOLD;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Captured straps are cleared in reset, loaded once, then frozen
	always_ff @(posedge clock) begin
		if (srst) begin
			straps <= '0;
		end else if (capture_now) begin
			straps <= next_straps; // [RULE_10]
		end
	end

	// PCI divisor: A low gives /4, A high B low /3, both high /2
	assign div_ratio = !straps.pci_div_a ? DIV_BY_4 :
		(straps.pci_div_b ? DIV_BY_2 : DIV_BY_3); // [RULE_02]
	assign next_div_count = (div_count >= div_ratio - 3'h1) ? 3'h0 : div_count + 3'h1;

	// Divider runs only once straps are held, so the ratio never changes mid-period
	always_ff @(posedge clock) begin
		if (srst || state != ST_HOLD) begin
			div_count     <= 3'h0;
			pci_clock_out <= 1'b0;
		end else begin
			div_count     <= next_div_count;
			// Compare the count before it advances, so the first high phase is full length
			pci_clock_out <= (div_count < (div_ratio >> 1)); // [RULE_02]
		end
	end

	// Register images; reserved bits read zero
	assign reg0_value = {straps.pll_range, straps.bus_local, straps.pci_div_a, 1'b0,
		straps.mem_sync, straps.pci_div_b, straps.pci_div_b}; // [RULE_03] [RULE_04] [RULE_06]
	assign reg2_value = {3'h0, straps.dot_out, 4'h0};          // [RULE_08]
	assign hclk_value = {straps.hclk_speed, 3'h0};             // [RULE_09]

	// Address decode for read-only strap registers
	assign next_rdata = (reg_addr == STRAP_REG0_OFFSET) ? reg0_value :
		(reg_addr == STRAP_REG2_OFFSET) ? reg2_value :
		(reg_addr == HCLK_STRAP_OFFSET) ? hclk_value : REG_RESET;

	// Registered outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata       <= REG_RESET;
			mem_host_sync   <= 1'b0;
			local_bus_mode  <= 1'b0;
			pci_pll_range   <= 2'h0;
			dot_clock_oe_n  <= 1'b1;
			hclk_speed_code <= 5'h00;
			straps_valid    <= 1'b0;
		end else begin
			reg_rdata       <= next_rdata;
			mem_host_sync   <= straps.mem_sync;   // [RULE_04]
			local_bus_mode  <= straps.bus_local;  // [RULE_05]
			pci_pll_range   <= straps.pll_range;  // [RULE_06]
			dot_clock_oe_n  <= !straps.dot_out;   // [RULE_08]
			hclk_speed_code <= straps.hclk_speed; // [RULE_09]
			straps_valid    <= (state == ST_HOLD);
		end
	end

	// Straps stay frozen once held
	a_straps_frozen: assert property ( // [RULE_10]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD) |=> $stable(straps))
		else $error("strap set changed after capture");

	// Register 0 loads pins 7..4 one cycle after the capture cycle
	a_reg0_load: assert property ( // [RULE_01]
		@(posedge clock) disable iff (srst)
		capture_now |=> (reg0_value[7:6] == $past(strap_sample_pins[7:6])
		&& reg0_value[4] == $past(strap_sample_pins[4])
		&& reg0_value[2] == $past(strap_sample_pins[5])))
		else $error("strap register 0 did not load pins 7..4");

	// A high and B low gives a three-cycle period, judged from the straps alone
	a_div_select: assert property ( // [RULE_02]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $rose(pci_clock_out) && straps.pci_div_a && !straps.pci_div_b)
		|-> ##3 $rose(pci_clock_out))
		else $error("PCI clock period is not three host cycles");

	// A low gives a four-cycle period whatever B is
	a_div_period: assert property ( // [RULE_02]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $rose(pci_clock_out) && !straps.pci_div_a)
		|-> ##4 $rose(pci_clock_out))
		else $error("PCI clock period is not four host cycles");

	// Both divisor straps high give a two-cycle period
	a_div_half: assert property ( // [RULE_02]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $rose(pci_clock_out) && straps.pci_div_a && straps.pci_div_b)
		|-> ##2 $rose(pci_clock_out))
		else $error("PCI clock period is not two host cycles");

	// Divide by four stays high for two host cycles
	a_div_duty: assert property ( // [RULE_02]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $rose(pci_clock_out) && !straps.pci_div_a)
		|=> pci_clock_out ##1 !pci_clock_out)
		else $error("PCI clock high phase is not two host cycles");

	// Divisor fields of register 0 mirror the captured straps
	a_reg0_fields: assert property ( // [RULE_03]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $rose(reg_addr == STRAP_REG0_OFFSET))
		|=> reg_rdata[1:0] == {2{straps.pci_div_b}} && reg_rdata[4] == straps.pci_div_a)
		else $error("strap register 0 divisor fields wrong");

	// Sync and bus mode outputs track the straps one cycle later
	a_mode_outputs: assert property ( // [RULE_04]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD) |=> mem_host_sync == $past(straps.mem_sync)
		&& local_bus_mode == $past(straps.bus_local))
		else $error("sync or bus mode output wrong");

	// Bus-select read back in bit 5 agrees with the bus mode output
	a_bus_select: assert property ( // [RULE_05]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $past(state) == ST_HOLD && $past(reg_addr) == STRAP_REG0_OFFSET)
		|-> reg_rdata[F0_BUS_SEL] == local_bus_mode)
		else $error("bus select bit wrong");

	// PLL range output matches register bits
	a_pll_range: assert property ( // [RULE_06]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD) ##1 (state == ST_HOLD) |-> pci_pll_range == reg0_value[7:6])
		else $error("PLL range output wrong");

	// Dot clock pin drives only when the strap is high
	a_dot_dir: assert property ( // [RULE_08]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD) |=> dot_clock_oe_n == !$past(straps.dot_out))
		else $error("dot clock direction wrong");

	// Host speed code is readable and drives the synthesizer
	a_hclk_speed: assert property ( // [RULE_09]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD) |=> hclk_speed_code == hclk_value[7:3])
		else $error("host clock speed code wrong");

	// Dot clock bit read back agrees with the pin direction output
	a_reg2_read: assert property ( // [RULE_08]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $past(state) == ST_HOLD && $past(reg_addr) == STRAP_REG2_OFFSET)
		|-> reg_rdata[F2_DOT_DIR] == !dot_clock_oe_n)
		else $error("dot clock bit read back wrong");

	// Speed field read back agrees with the synthesizer code
	a_hclk_read: assert property ( // [RULE_09]
		@(posedge clock) disable iff (srst)
		(state == ST_HOLD && $past(state) == ST_HOLD && $past(reg_addr) == HCLK_STRAP_OFFSET)
		|-> reg_rdata[FH_SPEED_LO +: 5] == hclk_speed_code)
		else $error("host speed field read back wrong");

	// Valid flag rises two edges after the single capture cycle
	a_valid_timing: assert property ( // [RULE_10]
		@(posedge clock) disable iff (srst)
		capture_now |-> !straps_valid ##2 straps_valid)
		else $error("straps valid flag timing wrong");

	// Reset parks the outputs, with the dot clock pin left as an input
	a_reset_outputs: assert property ( // [RULE_10]
		@(posedge clock)
		srst |=> (reg_rdata == REG_RESET && !pci_clock_out && !straps_valid && dot_clock_oe_n))
		else $error("outputs not parked during reset");
endmodule // power_on_strap_capture
`default_nettype wire

// >>> verif/strap_board.sv
/*
 Board strap resistor model for the power-on strap capture block.
 Assumes the pins are sampled on clock and traffic models later bus use.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_board #(
	parameter int PIN_COUNT = 64
) (
	input  wire logic                 clock,
	input  wire logic [PIN_COUNT-1:0] user_straps,
	input  wire logic                 traffic,
	output var  logic [PIN_COUNT-1:0] pins
);
	localparam logic [63:0] PULL_UP = 64'h0001_4400_00ed_4002;
	localparam logic [63:0] PULL_DN = 64'h0000_aa00_7800_0c80;
	logic [PIN_COUNT-1:0] bus_q = '0;
	// Traffic flips every cycle, so a late sample can never look like a strap
	always_ff @(posedge clock) begin
		bus_q <= ~bus_q;
	end
	// Marked pins follow their resistor whatever the user picked
	assign pins = traffic ? bus_q
		: (user_straps & ~PIN_COUNT'(PULL_DN)) | PIN_COUNT'(PULL_UP);
endmodule // strap_board
`default_nettype wire

// >>> verif/power_on_strap_capture_tb.sv
/*
 Testbench for the power-on strap capture block: reset, register reads, outputs.
 Assumes the strap_board model stands on the memory data pins.
*/
`timescale 1ns/1ps
`default_nettype none
module power_on_strap_capture_tb;
	import strap_capture_pkg::*;
	logic        clock = 1'b0, srst = 1'b1, traffic = 1'b0;
	logic [63:0] user_straps = '0, pins, p;
	logic [7:0]  reg_addr = 8'h00, reg_rdata, rd;
	logic        pci_clock_out, mem_host_sync, local_bus_mode, dot_clock_oe_n, straps_valid;
	logic [1:0]  pci_pll_range;
	logic [4:0]  hclk_speed_code;
	int          failures = 0, total_checks = 0, cycles = 0;
	logic [63:0] cfgs [4] = '{64'h0, 64'h0000_1000_0510_0034, 64'h0000_0000_0202_00d8, 64'h2_0000};

	power_on_strap_capture power_on_strap_capture_i (.clock(clock), .srst(srst),
		.strap_sample_pins(pins), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
		.pci_clock_out(pci_clock_out), .mem_host_sync(mem_host_sync),
		.local_bus_mode(local_bus_mode), .pci_pll_range(pci_pll_range),
		.dot_clock_oe_n(dot_clock_oe_n), .hclk_speed_code(hclk_speed_code),
		.straps_valid(straps_valid));
	strap_board strap_board_i (.clock(clock), .user_straps(user_straps), .traffic(traffic),
		.pins(pins));

	task automatic wrap_up();
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask
	// Read data answers one edge after the address is taken
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock) reg_addr <= a;
		@(posedge clock);
		#1 d = reg_rdata;
	endtask
	// Twelve samples hold whole periods of /2, /3 and /4 alike
	task automatic div_chk(input int r);
		logic [11:0] s;
		int          hi, rises;
		hi = 0;
		rises = 0;
		for (int i = 0; i < 12; i++) begin
			@(posedge clock);
			#1 s[i] = pci_clock_out;
		end
		for (int i = 0; i < 12; i++) begin
			hi += s[i];
			rises += (s[i] & !s[(i + 11) % 12]);
		end
		chk("pci_high", 8'(12 / r * (r >> 1)), 8'(hi));
		chk("pci_rises", 8'(12 / r), 8'(rises));
	endtask
	// One reset, capture and readback pass for one board set-up
	task automatic run(input logic [63:0] cfg);
		int r;
		@(posedge clock) begin
			srst <= 1'b1;
			traffic <= 1'b0;
			user_straps <= cfg;
		end
		repeat (3) @(posedge clock);
		#1 p = pins;
		chk("valid_rst", 8'h00, 8'(straps_valid));
		@(posedge clock) srst <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk("valid", 8'h01, 8'(straps_valid));
		@(posedge clock) traffic <= 1'b1;
		rd_reg(STRAP_REG0_OFFSET, rd);
		chk("reg0", {p[7], p[6], p[44], p[4], 1'b0, p[5], p[17], p[17]}, rd);
		rd_reg(STRAP_REG2_OFFSET, rd);
		chk("reg2", {3'h0, p[20], 4'h0}, rd);
		rd_reg(HCLK_STRAP_OFFSET, rd);
		chk("hclk_reg", {p[3], p[2], p[26], p[25], p[24], 3'h0}, rd);
		rd_reg(8'h4b, rd);
		chk("unmapped", REG_RESET, rd);
		chk("sync", 8'(p[5]), 8'(mem_host_sync));
		chk("bus", 8'(p[44]), 8'(local_bus_mode));
		chk("pll", 8'(p[7:6]), 8'(pci_pll_range));
		chk("dot_oe_n", 8'(!p[20]), 8'(dot_clock_oe_n));
		chk("speed", 8'({p[3], p[2], p[26], p[25], p[24]}), 8'(hclk_speed_code));
		r = !p[4] ? 4 : (p[17] ? 2 : 3);
		div_chk(r);
	endtask

	// Clock at 40 MHz
	initial forever #12.5 clock = ~clock;
	// A hang counts as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			wrap_up();
		end
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge clock);
		foreach (cfgs[i]) run(cfgs[i]);
		wrap_up();
	end
endmodule // power_on_strap_capture_tb
`default_nettype wire
